// ---- core/wsm_ctrl.sv ----
`timescale 1ns/10ps
module wsm_ctrl (
  input  wire logic             mclk,
  input  wire logic             rst,
  wsm_if.ctl                    lk,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output      logic [31:0]      reg_rdata
);
  import wsm_pkg::*;

  // smallest power of two holding the object, capped at 32k
  function automatic logic [SZW-1:0] fit_exp(input logic [LW-1:0] len);
    fit_exp = SZ_MAX;
    for (int n = 15; n >= 0; n--)
      if ((17'h1 << n) >= len)
        fit_exp = SZW'(n);
  endfunction

  logic [CTRL_W-1:0] ctrl_ff;
  logic [AW-1:0]     base_ff;
  logic [SZW-1:0]    size_ff;
  logic [AW-1:0]     sel_ff;
  logic [LW-1:0]     olen_ff;
  logic [AW-1:0]     ref_ff;
  logic [15:0]       stat_ff;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl_ff <= CTRL_RST;
      base_ff <= '0;
      size_ff <= '0;
      sel_ff  <= '0;
      olen_ff <= '0;
      ref_ff  <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == R_CTRL)
        ctrl_ff <= reg_wdata[CTRL_W-1:0];
      else if (reg_addr == R_BASE)
        base_ff <= reg_wdata[AW-1:0];
      else if (reg_addr == R_SIZE)
        size_ff <= reg_wdata[SZW-1:0];
      else if (reg_addr == R_SEL)
        sel_ff <= reg_wdata[AW-1:0];
      else if (reg_addr == R_OLEN)
        olen_ff <= reg_wdata[LW-1:0];
      else if (reg_addr == R_REF)
        ref_ff <= reg_wdata[AW-1:0];
    end
  end

  // commands to the device, one-cycle strobes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lk.op_req  <= 1'b0;
      lk.op_open <= 1'b0;
      lk.op_win  <= '0;
      lk.op_base <= '0;
      lk.op_size <= '0;
      lk.op_sel  <= '0;
      lk.op_dir  <= '0;
      lk.op_mode <= 1'b0;
      lk.op_ovl  <= 1'b0;
      lk.ps_req  <= 1'b0;
      lk.ps_wr   <= 1'b0;
      lk.ps_addr <= '0;
      lk.tb_we   <= 1'b0;
      lk.tb_idx  <= '0;
      lk.tb_ent  <= '0;
      lk.flt_clr <= 1'b0;
    end
    else
    begin
      lk.op_req  <= reg_wr && reg_addr == R_CMD;
      lk.ps_req  <= reg_wr && reg_addr == R_REFGO;
      lk.tb_we   <= reg_wr && reg_addr == R_TBL;
      lk.flt_clr <= reg_wr && reg_addr == R_FCLR;
      if (reg_wr && reg_addr == R_CMD)
      begin
        lk.op_open <= reg_wdata[0];
        lk.op_win  <= ctrl_ff[F_WIN+2:F_WIN];
        lk.op_base <= base_ff;
        lk.op_size <= ctrl_ff[F_AUTO] ? fit_exp(olen_ff) : size_ff;
        lk.op_sel  <= sel_ff;
        lk.op_dir  <= ctrl_ff[F_DIR+1:F_DIR];
        lk.op_mode <= ctrl_ff[F_MODE];
        lk.op_ovl  <= ctrl_ff[F_OVL] | ctrl_ff[F_SHM];
      end
      if (reg_wr && reg_addr == R_REFGO)
      begin
        lk.ps_wr   <= reg_wdata[0];
        lk.ps_addr <= ref_ff;
      end
      if (reg_wr && reg_addr == R_TBL)
      begin
        lk.tb_idx <= reg_wdata[OIW-1:0];
        lk.tb_ent <= reg_wdata[T_TOP:T_ENT];
      end
    end
  end

  // status captured from the device answers
  always_ff @(posedge mclk)
  begin
    if (rst)
      stat_ff <= '0;
    else
    begin
      if (lk.op_done)
        stat_ff[6:0] <= {lk.op_tstat, lk.op_code, 1'b1};
      else if (lk.op_req)
        stat_ff[0] <= 1'b0;
      if (lk.ps_ack || lk.ps_req)
        stat_ff[10:7] <= {lk.ps_fault, lk.ps_inhibit, lk.ps_xfer, lk.ps_ack};
      stat_ff[11]    <= lk.flt_irq;
      stat_ff[14:12] <= lk.flt_win;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (!reg_rd)
      reg_rdata <= '0;
    else if (reg_addr == R_CTRL)
      reg_rdata <= {23'h0, ctrl_ff};
    else if (reg_addr == R_BASE)
      reg_rdata <= {16'h0, base_ff};
    else if (reg_addr == R_SIZE)
      reg_rdata <= {28'h0, size_ff};
    else if (reg_addr == R_SEL)
      reg_rdata <= {16'h0, sel_ff};
    else if (reg_addr == R_OLEN)
      reg_rdata <= {15'h0, olen_ff};
    else if (reg_addr == R_REF)
      reg_rdata <= {16'h0, ref_ff};
    else if (reg_addr == R_STAT)
      reg_rdata <= {16'h0, stat_ff};
    else
      reg_rdata <= '0;
  end
endmodule // wsm_ctrl

// ---- core/wsm_device.sv ----
// Functional notes
// - random subrange sizes are powers of two
// - block window zero reaches whole object
// - controller rounds object length up to power
// - window is lesser of subrange, object
// - base is offset in device range
// - base aligned to subrange size
// - subranges never overlap, stay in range
// - one window per object or refinement
// - set windowed flag on base object
// - only single segment data objects
// - object must be present in context
// - requested direction within granted rights
// - wrong direction reference raises fault
// - four transfer states, two block only
// - open in progress, fault terminates
// - closing random window is normal end
// - mode only on windows zero, one
// - overlay window inhibits co-located memory
// - closed overlay window stops inhibiting
// - controller sets overlay over shared memory
// - respond only on hit of a subrange not closed, faulted windows included
// - fault recorded, irq, later acks move nothing
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module wsm_device (
  input  wire logic             mclk,
  input  wire logic             rst,
  wsm_if.dev                    lk,
  output      logic             hm_req,
  output      logic             hm_wr,
  output      logic [2:0]       hm_obj,
  output      logic [16:0]      hm_disp
);
  import wsm_pkg::*;

  function automatic logic [LW-1:0] pow2(input logic [SZW-1:0] n);
    pow2 = 17'h1 << n;
  endfunction

  function automatic logic [AW-1:0] szmask(input logic [SZW-1:0] n);
    szmask = AW'(pow2(n) - 17'h1);
  endfunction

  function automatic logic in_sub(input logic [AW-1:0] a, input logic [AW-1:0] b,
                                  input logic [SZW-1:0] n);
    in_sub = ((a ^ b) & ~szmask(n)) == 16'h0000;
  endfunction

  wsm_wstate_t    st_ff   [NWIN];
  logic [AW-1:0]  base_ff [NWIN];
  logic [SZW-1:0] szx_ff  [NWIN];
  logic [OIW-1:0] obj_ff  [NWIN];
  logic [OIW-1:0] bob_ff  [NWIN];
  logic [1:0]     dir_ff  [NWIN];
  wsm_tstat_t     ts_ff   [NWIN];
  logic           mode_ff [NWIN];
  logic           ovl_ff  [NWIN];
  logic [LW-1:0]  len_ff  [NWIN];
  logic [LW-1:0]  blk_ff;
  wsm_obj_t       tbl_ff  [NOBJ];
  logic [NOBJ-1:0] wnd_ff;

  wsm_code_t      nxt_code;
  wsm_obj_t       ent;
  logic [OIW-1:0] osel;
  logic [1:0]     wi;
  logic           clash;
  logic           mine;
  logic [SZW-1:0] mx;
  logic [LW-1:0]  nxt_len;
  logic           hit;
  logic [2:0]     hw;
  logic [LW-1:0]  disp;
  logic           blkref;
  logic           bad;
  logic           good;
  logic           newflt;

  assign osel = lk.op_sel[SEL_LO+OIW-1:SEL_LO];
  assign wi   = lk.op_win[1:0];
  assign ent  = tbl_ff[osel];

  // open request checks
  always_comb
  begin
    clash = 1'b0;
    for (int j = 0; j < NWIN; j++)
    begin
      mx = (szx_ff[j] > lk.op_size) ? szx_ff[j] : lk.op_size;
      if (3'(j) != lk.op_win && st_ff[j] != WS_CLOSED && in_sub(base_ff[j], lk.op_base, mx))
        clash = 1'b1;
    end
    mine = st_ff[wi] != WS_CLOSED && bob_ff[wi] == ent.bidx;
    if (lk.op_win > WIN_CTL)
      nxt_code = OC_BADWIN;
    else if (lk.op_mode && lk.op_win >= WIN_MLIM)
      nxt_code = OC_MODE;
    else if (lk.op_win == WIN_CTL)
      nxt_code = OC_BADWIN;
    else if ((lk.op_base & szmask(lk.op_size)) != 16'h0000)
      nxt_code = OC_ALIGN;
    else if ({1'b0, lk.op_base} + pow2(lk.op_size) > RANGE_TOP)
      nxt_code = OC_RANGE;
    else if (clash)
      nxt_code = OC_OVERLAP;
    else if (!ent.present)
      nxt_code = OC_ABSENT;
    else if (!ent.single || !ent.dseg)
      nxt_code = OC_TYPE;
    else if (wnd_ff[ent.bidx] && !mine)
      nxt_code = OC_WINDOWED;
    else if ((lk.op_dir & ~ent.rights) != 2'h0)
      nxt_code = OC_RIGHTS;
    else
      nxt_code = OC_OK;
    // block window sees the object, random the lesser of both
    if (lk.op_win == WIN_BLK && lk.op_mode)
      nxt_len = ent.len;
    else
      nxt_len = (pow2(lk.op_size) < ent.len) ? pow2(lk.op_size) : ent.len;
  end

  // address recognition and per-reference checks
  always_comb
  begin
    hit = 1'b0;
    hw  = 3'h0;
    for (int j = 0; j < NWIN; j++)
      if (st_ff[j] != WS_CLOSED && in_sub(lk.ps_addr, base_ff[j], szx_ff[j]))
      begin
        hit = 1'b1;
        hw  = 3'(j);
      end
    blkref = hw == WIN_BLK && mode_ff[0];
    disp   = blkref ? blk_ff : {1'b0, lk.ps_addr & szmask(szx_ff[hw])};
    bad    = (lk.ps_wr ? !dir_ff[hw][1] : !dir_ff[hw][0]) || disp >= len_ff[hw];
    good   = lk.ps_req && hit && st_ff[hw] == WS_OPEN && !bad;
    newflt = lk.ps_req && hit && st_ff[hw] == WS_OPEN && bad;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      for (int k = 0; k < NOBJ; k++)
        tbl_ff[k] <= '0;
    else if (lk.tb_we)
      tbl_ff[lk.tb_idx] <= lk.tb_ent;
  end

  // window state, attributes and windowed flags
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wnd_ff <= '0;
      blk_ff <= '0;
      for (int j = 0; j < NWIN; j++)
      begin
        st_ff[j]   <= WS_CLOSED;
        base_ff[j] <= '0;
        szx_ff[j]  <= '0;
        obj_ff[j]  <= '0;
        bob_ff[j]  <= '0;
        dir_ff[j]  <= '0;
        ts_ff[j]   <= TS_PROG;
        mode_ff[j] <= 1'b0;
        ovl_ff[j]  <= 1'b0;
        len_ff[j]  <= '0;
      end
    end
    else
    begin
      if (newflt)
      begin
        st_ff[hw] <= WS_FAULT;
        ts_ff[hw] <= TS_FAULT;
      end
      else if (good && blkref)
      begin
        blk_ff <= blk_ff + 17'h1;
        if (blk_ff + 17'h1 == len_ff[0])
          ts_ff[0] <= TS_RUNOUT;
      end
      if (lk.op_req && lk.op_win < WIN_CTL)
      begin
        // a reopen first drops the old mapping
        if (st_ff[wi] != WS_CLOSED)
          wnd_ff[bob_ff[wi]] <= 1'b0;
        st_ff[wi] <= WS_CLOSED;
        if (lk.op_open && nxt_code == OC_OK)
        begin
          st_ff[wi]        <= WS_OPEN;
          wnd_ff[ent.bidx] <= 1'b1;
          base_ff[wi]      <= lk.op_base;
          szx_ff[wi]       <= lk.op_size;
          obj_ff[wi]       <= osel;
          bob_ff[wi]       <= ent.bidx;
          dir_ff[wi]       <= lk.op_dir;
          ts_ff[wi]        <= TS_PROG;
          mode_ff[wi]      <= lk.op_mode;
          ovl_ff[wi]       <= lk.op_ovl;
          len_ff[wi]       <= nxt_len;
          if (wi == WIN_BLK[1:0])
            blk_ff <= '0;
        end
      end
    end
  end

  // open and close answers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lk.op_done  <= 1'b0;
      lk.op_code  <= OC_OK;
      lk.op_tstat <= TS_PROG;
    end
    else
    begin
      lk.op_done  <= lk.op_req;
      lk.op_code  <= OC_OK;
      lk.op_tstat <= ts_ff[wi];
      if (lk.op_req && (lk.op_open || lk.op_win >= WIN_CTL))
        lk.op_code <= nxt_code;
      else if (lk.op_req && mode_ff[0] && wi == WIN_BLK[1:0] && st_ff[0] == WS_OPEN
               && ts_ff[0] == TS_PROG)
        lk.op_tstat <= TS_FORCED;
      if (lk.op_req && lk.op_open && nxt_code == OC_OK)
        lk.op_tstat <= TS_PROG;
    end
  end

  // peripheral bus answer and host memory request
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lk.ps_ack     <= 1'b0;
      lk.ps_xfer    <= 1'b0;
      lk.ps_fault   <= 1'b0;
      lk.ps_inhibit <= 1'b0;
      hm_req        <= 1'b0;
      hm_wr         <= 1'b0;
      hm_obj        <= '0;
      hm_disp       <= '0;
    end
    else
    begin
      lk.ps_ack     <= lk.ps_req && hit;
      lk.ps_xfer    <= good;
      lk.ps_fault   <= newflt;
      lk.ps_inhibit <= lk.ps_req && hit && ovl_ff[hw];
      hm_req        <= good;
      hm_wr         <= lk.ps_wr;
      hm_obj        <= obj_ff[hw];
      hm_disp       <= disp;
    end
  end

  // fault interrupt, a new fault beats the clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lk.flt_irq <= 1'b0;
      lk.flt_win <= '0;
    end
    else if (newflt)
    begin
      lk.flt_irq <= 1'b1;
      lk.flt_win <= hw;
    end
    else if (lk.flt_clr)
      lk.flt_irq <= 1'b0;
  end
endmodule // wsm_device

// ---- shared/wsm_if.sv ----
`timescale 1ns/10ps
interface wsm_if;
  import wsm_pkg::*;
  // window open/close channel
  logic             op_req;
  logic             op_open;
  logic [2:0]       op_win;
  logic [AW-1:0]    op_base;
  logic [SZW-1:0]   op_size;
  logic [AW-1:0]    op_sel;
  logic [1:0]       op_dir;
  logic             op_mode;
  logic             op_ovl;
  logic             op_done;
  wsm_code_t        op_code;
  wsm_tstat_t       op_tstat;
  // object table load
  logic             tb_we;
  logic [OIW-1:0]   tb_idx;
  wsm_obj_t         tb_ent;
  // peripheral bus reference
  logic             ps_req;
  logic             ps_wr;
  logic [AW-1:0]    ps_addr;
  logic             ps_ack;
  logic             ps_xfer;
  logic             ps_fault;
  logic             ps_inhibit;
  // fault interrupt to the attached processor
  logic             flt_irq;
  logic [2:0]       flt_win;
  logic             flt_clr;

  modport dev (
    input  op_req, op_open, op_win, op_base, op_size, op_sel, op_dir, op_mode, op_ovl,
    input  tb_we, tb_idx, tb_ent, ps_req, ps_wr, ps_addr, flt_clr,
    output op_done, op_code, op_tstat, ps_ack, ps_xfer, ps_fault, ps_inhibit,
    output flt_irq, flt_win
  );
  modport ctl (
    output op_req, op_open, op_win, op_base, op_size, op_sel, op_dir, op_mode, op_ovl,
    output tb_we, tb_idx, tb_ent, ps_req, ps_wr, ps_addr, flt_clr,
    input  op_done, op_code, op_tstat, ps_ack, ps_xfer, ps_fault, ps_inhibit,
    input  flt_irq, flt_win
  );
endinterface

// ---- shared/wsm_pkg.sv ----
package wsm_pkg;
  // window and object table geometry
  localparam int NWIN = 5;
  localparam int NOBJ = 8;
  localparam int OIW  = 3;
  localparam int AW   = 16;
  localparam int LW   = 17;
  localparam int SZW  = 4;
  localparam int DW   = 32;
  localparam int RAW  = 4;

  localparam logic [SZW-1:0] SZ_MAX    = 4'hf;      // 32k bytes
  localparam logic [LW-1:0]  RANGE_TOP = 17'h10000; // 64k byte device range
  localparam logic [2:0]     WIN_BLK   = 3'h0;
  localparam logic [2:0]     WIN_MLIM  = 3'h2;      // first window with no mode
  localparam logic [2:0]     WIN_CTL   = 3'h4;      // control window, fixed
  localparam int             SEL_LO    = 2;         // scaled index above segment bits

  typedef enum logic [1:0] {
    WS_CLOSED = 2'h0,
    WS_OPEN   = 2'h1,
    WS_FAULT  = 2'h2
  } wsm_wstate_t;

  typedef enum logic [1:0] {
    TS_PROG   = 2'h0,
    TS_FAULT  = 2'h1,
    TS_RUNOUT = 2'h2,
    TS_FORCED = 2'h3
  } wsm_tstat_t;

  typedef enum logic [3:0] {
    OC_OK       = 4'h0,
    OC_BADWIN   = 4'h1,
    OC_MODE     = 4'h2,
    OC_ALIGN    = 4'h3,
    OC_RANGE    = 4'h4,
    OC_OVERLAP  = 4'h5,
    OC_ABSENT   = 4'h6,
    OC_TYPE     = 4'h7,
    OC_WINDOWED = 4'h8,
    OC_RIGHTS   = 4'h9
  } wsm_code_t;

  typedef struct packed {
    logic [LW-1:0]  len;
    logic [OIW-1:0] bidx;
    logic [1:0]     rights;
    logic           dseg;
    logic           single;
    logic           present;
  } wsm_obj_t;

  // controller register offsets
  localparam logic [RAW-1:0] R_CTRL  = 4'h0;
  localparam logic [RAW-1:0] R_BASE  = 4'h1;
  localparam logic [RAW-1:0] R_SIZE  = 4'h2;
  localparam logic [RAW-1:0] R_SEL   = 4'h3;
  localparam logic [RAW-1:0] R_OLEN  = 4'h4;
  localparam logic [RAW-1:0] R_CMD   = 4'h5;
  localparam logic [RAW-1:0] R_REF   = 4'h6;
  localparam logic [RAW-1:0] R_REFGO = 4'h7;
  localparam logic [RAW-1:0] R_STAT  = 4'h8;
  localparam logic [RAW-1:0] R_TBL   = 4'h9;
  localparam logic [RAW-1:0] R_FCLR  = 4'ha;

  // field positions
  localparam int F_WIN  = 0;
  localparam int F_DIR  = 3;
  localparam int F_MODE = 5;
  localparam int F_OVL  = 6;
  localparam int F_AUTO = 7;
  localparam int F_SHM  = 8;
  localparam int CTRL_W = 9;
  localparam int T_ENT  = 3;
  localparam int T_TOP  = 27;
  localparam logic [8:0] CTRL_RST = 9'h000;
endpackage

// ---- verif/test_window_subrange_mapper.sv ----
`timescale 1ns/10ps
module test_window_subrange_mapper;
  import wsm_pkg::*;
  logic        mclk;
  logic        rst;
  logic        reg_wr;
  logic        reg_rd;
  logic        rd_d;
  logic        hm_req;
  logic        hm_wr;
  logic [2:0]  hm_obj;
  logic [16:0] hm_disp;
  logic [15:0] exp_base;
  logic [2:0]  exp_obj;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] rnd;
  logic [6:0]  opq[$];
  logic [7:0]  refq[$];
  logic [63:0] rdq[$];
  logic [20:0] hmq[$];
  int          err_total;
  int          comparisons;
  int          seed;
  wsm_if lk();
  wsm_device u_wsm_device (.mclk(mclk), .rst(rst), .lk(lk.dev), .hm_req(hm_req),
    .hm_wr(hm_wr), .hm_obj(hm_obj), .hm_disp(hm_disp));
  wsm_ctrl u_wsm_ctrl (.mclk(mclk), .rst(rst), .lk(lk.ctl), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  wsm_monitor u_wsm_monitor (.mclk(mclk), .rst(rst), .op_req(lk.op_req),
    .op_open(lk.op_open), .op_win(lk.op_win), .op_base(lk.op_base), .op_size(lk.op_size),
    .op_mode(lk.op_mode), .op_done(lk.op_done), .op_code(lk.op_code),
    .op_tstat(lk.op_tstat), .ps_req(lk.ps_req), .ps_ack(lk.ps_ack), .ps_xfer(lk.ps_xfer),
    .ps_fault(lk.ps_fault), .ps_inhibit(lk.ps_inhibit), .flt_irq(lk.flt_irq),
    .flt_clr(lk.flt_clr));

  task automatic close_out;
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_op;
    logic [6:0] q;
    if (opq.size() == 0)
      cmp(32'h1, 32'h0);
    else
    begin
      q = opq.pop_front();
      cmp({26'h0, lk.op_code, lk.op_tstat & {2{q[0]}}}, {26'h0, q[6:3], q[2:1] & {2{q[0]}}});
    end
  endtask

  task automatic chk_ref;
    logic [7:0] q;
    if (refq.size() == 0)
      cmp(32'h1, 32'h0);
    else
    begin
      q = refq.pop_front();
      cmp({28'h0, {lk.ps_xfer, lk.ps_fault, lk.ps_inhibit, hm_req} & q[3:0]},
        {28'h0, q[7:4] & q[3:0]});
    end
  endtask

  task automatic chk_rd;
    logic [63:0] q;
    if (rdq.size() == 0)
      cmp(32'h1, 32'h0);
    else
    begin
      q = rdq.pop_front();
      cmp(reg_rdata & q[31:0], q[63:32] & q[31:0]);
    end
  endtask

  task automatic chk_hm;
    logic [20:0] q;
    if (hmq.size() == 0)
      cmp(32'h1, 32'h0);
    else
    begin
      q = hmq.pop_front();
      cmp({11'h0, hm_obj, hm_wr, hm_disp}, {11'h0, q});
    end
  endtask

  // result watcher: oldest note against each answer
  always @(posedge mclk)
  begin
    rd_d <= reg_rd;
    if (lk.op_done === 1'b1)
      chk_op();
    if (lk.ps_ack === 1'b1)
      chk_ref();
    if (rd_d === 1'b1)
      chk_rd();
    if (hm_req === 1'b1)
      chk_hm();
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    rdq.push_back({e, m});
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
  endtask

  task automatic ld(input logic [2:0] i, input logic [16:0] n, input logic [2:0] b,
    input logic [1:0] r, input logic ds);
    wsm_obj_t t;
    t = '{len: n, bidx: b, rights: r, dseg: ds, single: 1'b1, present: 1'b1};
    wr(R_TBL, {4'h0, t, i});
  endtask

  task automatic op(input logic [2:0] w, input logic [1:0] d, input logic md,
    input logic v, input logic [15:0] b, input logic [3:0] s, input logic [2:0] o,
    input wsm_code_t c);
    wr(R_CTRL, {25'h0, v, md, d, w});
    wr(R_BASE, {16'h0, b});
    wr(R_SIZE, {28'h0, s});
    wr(R_SEL, {27'h0, o, 2'h0});
    opq.push_back({c, TS_PROG, c == OC_OK});
    wr(R_CMD, 32'h1);
    repeat (3) @(posedge mclk);
  endtask

  task automatic cl(input logic [2:0] w, input wsm_tstat_t t);
    wr(R_CTRL, {29'h0, w});
    opq.push_back({OC_OK, t, 1'b1});
    wr(R_CMD, 32'h0);
    repeat (3) @(posedge mclk);
  endtask

  // e and m: {xfer, fault, inhibit, host request}; m of zero means silence
  task automatic rf(input logic [15:0] a, input logic w, input logic [3:0] e,
    input logic [3:0] m);
    if (m != 4'h0)
      refq.push_back({e, m});
    if (e[0] && m[0])
      hmq.push_back({exp_obj, w, 17'(a - exp_base)});
    wr(R_REF, {16'h0, a});
    wr(R_REFGO, {31'h0, w});
    repeat (3) @(posedge mclk);
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial
  begin
    repeat (5000) @(posedge mclk);
    err_total++;
    close_out();
  end

  initial
  begin
    seed = 95474;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    ld(3'h0, 17'h00064, 3'h0, 2'h3, 1'b1);
    ld(3'h1, 17'h01000, 3'h1, 2'h1, 1'b1);
    ld(3'h2, 17'h00032, 3'h0, 2'h3, 1'b1);
    ld(3'h3, 17'h00040, 3'h3, 2'h3, 1'b0);
    ld(3'h5, 17'h00010, 3'h5, 2'h3, 1'b1);
    ld(3'h6, 17'h00200, 3'h6, 2'h1, 1'b1);
    op(3'h2, 2'h3, 1'b0, 1'b0, 16'h1000, 4'h7, 3'h0, OC_OK);
    op(3'h1, 2'h3, 1'b0, 1'b0, 16'h2000, 4'h4, 3'h2, OC_WINDOWED);
    op(3'h3, 2'h3, 1'b0, 1'b0, 16'h2000, 4'h4, 3'h3, OC_TYPE);
    op(3'h3, 2'h3, 1'b0, 1'b0, 16'h2000, 4'h4, 3'h4, OC_ABSENT);
    op(3'h3, 2'h3, 1'b0, 1'b0, 16'h2000, 4'h4, 3'h1, OC_RIGHTS);
    op(3'h3, 2'h3, 1'b1, 1'b0, 16'h2000, 4'h4, 3'h5, OC_MODE);
    op(3'h4, 2'h3, 1'b0, 1'b0, 16'h2000, 4'h4, 3'h5, OC_BADWIN);
    op(3'h5, 2'h3, 1'b0, 1'b0, 16'h2000, 4'h4, 3'h5, OC_BADWIN);
    op(3'h3, 2'h3, 1'b0, 1'b0, 16'h2010, 4'h8, 3'h5, OC_ALIGN);
    op(3'h3, 2'h3, 1'b0, 1'b0, 16'h1040, 4'h4, 3'h5, OC_OVERLAP);
    rd(R_STAT, {27'h0, OC_OVERLAP, 1'b0}, 32'h0000001e);
    rd(4'hb, 32'h0, 32'hffffffff);
    $display("test open checks done");
    exp_base = 16'h1000;
    exp_obj  = 3'h0;
    repeat (4)
    begin
      rnd = $random(seed);
      rf(16'h1000 + 16'(rnd % 32'd100), rnd[31], 4'h9, 4'hf);
    end
    rf(16'h1064, 1'b0, 4'h4, 4'hf);
    op(3'h3, 2'h1, 1'b0, 1'b1, 16'h8000, 4'hc, 3'h1, OC_OK);
    exp_base = 16'h8000;
    exp_obj  = 3'h1;
    rf(16'h8010, 1'b0, 4'hb, 4'hf);
    rf(16'h8010, 1'b1, 4'h6, 4'hf);
    rf(16'h8010, 1'b0, 4'h0, 4'hd);
    rd(R_STAT, 32'h00003800, 32'h00007800);
    wr(R_FCLR, 32'h1);
    repeat (2) @(posedge mclk);
    rd(R_STAT, 32'h0, 32'h00000800);
    $display("test references done");
    cl(3'h3, TS_FAULT);
    rf(16'h8010, 1'b0, 4'h0, 4'h0);
    rf(16'h0500, 1'b0, 4'h0, 4'h0);
    cl(3'h2, TS_FAULT);
    op(3'h1, 2'h3, 1'b0, 1'b0, 16'h3000, 4'h2, 3'h5, OC_OK);
    exp_base = 16'h3000;
    exp_obj  = 3'h5;
    rf(16'h3003, 1'b1, 4'h9, 4'hf);
    rf(16'h3004, 1'b0, 4'h0, 4'h0);
    cl(3'h1, TS_PROG);
    $display("test close done");
    op(3'h0, 2'h1, 1'b1, 1'b0, 16'h4000, 4'h0, 3'h6, OC_OK);
    exp_base = 16'h4000;
    exp_obj  = 3'h6;
    rf(16'h4000, 1'b0, 4'h9, 4'hf);
    exp_base = 16'h3fff;
    rf(16'h4000, 1'b0, 4'h9, 4'hf);
    cl(3'h0, TS_FORCED);
    // block pointer walks the whole object, then the count runs out
    op(3'h0, 2'h2, 1'b1, 1'b0, 16'h4000, 4'h0, 3'h5, OC_OK);
    exp_obj = 3'h5;
    for (int k = 0; k < 16; k++)
    begin
      exp_base = 16'h4000 - 16'(k);
      rf(16'h4000, 1'b1, 4'h9, 4'hf);
    end
    cl(3'h0, TS_RUNOUT);
    $display("test block done");
    // size fitted to object length, shared memory forces overlay
    wr(R_OLEN, 32'h00000010);
    wr(R_BASE, 32'h00005000);
    wr(R_SEL, 32'h00000014);
    wr(R_CTRL, 32'h0000019a);
    opq.push_back({OC_OK, TS_PROG, 1'b1});
    wr(R_CMD, 32'h1);
    repeat (3) @(posedge mclk);
    exp_base = 16'h5000;
    rf(16'h500f, 1'b1, 4'hb, 4'hf);
    rf(16'h5010, 1'b0, 4'h0, 4'h0);
    cl(3'h2, TS_PROG);
    $display("test auto size done");
    repeat (4) @(posedge mclk);
    if (opq.size() + refq.size() + rdq.size() != 0)
      err_total++;
    close_out();
  end
endmodule // test_window_subrange_mapper

// ---- verif/wsm_monitor.sv ----
`timescale 1ns/10ps
module wsm_monitor (
  input wire logic                mclk,
  input wire logic                rst,
  input wire logic                op_req,
  input wire logic                op_open,
  input wire logic [2:0]          op_win,
  input wire logic [15:0]         op_base,
  input wire logic [3:0]          op_size,
  input wire logic                op_mode,
  input wire logic                op_done,
  input wire wsm_pkg::wsm_code_t  op_code,
  input wire wsm_pkg::wsm_tstat_t op_tstat,
  input wire logic                ps_req,
  input wire logic                ps_ack,
  input wire logic                ps_xfer,
  input wire logic                ps_fault,
  input wire logic                ps_inhibit,
  input wire logic                flt_irq,
  input wire logic                flt_clr
);
  import wsm_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  done_timing_a: assert property (op_req |=> op_done)
    else $error("open or close got no answer");
  open_prog_a: assert property ((op_req && op_open) ##1 (op_done && op_code == OC_OK)
    |-> op_tstat == TS_PROG) else $error("open did not start in progress");
  mode_fault_a: assert property (op_req && op_open && op_mode
    && (op_win == 3'h2 || op_win == 3'h3) |=> op_code == OC_MODE)
    else $error("mode on window two or three accepted");
  align_fault_a: assert property (op_req && op_open && !op_mode && op_win < 3'h4
    && ((op_base & ((16'h0001 << op_size) - 16'h0001)) != 16'h0000)
    |=> op_code == OC_ALIGN) else $error("misaligned base accepted");
  ref_silent_a: assert property (ps_ack |-> $past(ps_req))
    else $error("acknowledge without a reference");
  fault_ack_a: assert property (ps_fault |-> ps_ack && !ps_xfer)
    else $error("faulted reference moved data");
  fault_irq_a: assert property (ps_fault |-> flt_irq)
    else $error("fault raised no interrupt");
  irq_hold_a: assert property (flt_irq && !flt_clr |=> flt_irq)
    else $error("interrupt dropped without clear");
  inhibit_ack_a: assert property (ps_inhibit |-> ps_ack)
    else $error("inhibit outside a recognised reference");
endmodule // wsm_monitor
